// [core/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Sizes
    localparam int LINES = 32;
    localparam int PRIO_W = 2;
    localparam int EXC_W = 6;
    localparam int ADDR_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // Exception numbers
    localparam logic [5:0] EXC_NONE = 6'h00;
    localparam logic [5:0] EXC_RESET = 6'h01;
    localparam logic [5:0] EXC_NMI = 6'h02;
    localparam logic [5:0] EXC_FAULT = 6'h03;
    localparam logic [5:0] EXC_SVC = 6'h0B;
    localparam logic [5:0] EXC_DEFERRED_SERVICE_EXCEPTION = 6'h0E;
    localparam logic [5:0] EXC_TICK = 6'h0F;
    localparam logic [5:0] EXC_LINE_FIRST = 6'h10;
    localparam logic [5:0] EXC_LINE_LAST = 6'h2F;

    ////////////////////////////////////////////////////////////////////////
    // Urgency ranks, lower is more urgent
    localparam logic [2:0] RANK_RESET = 3'h0;
    localparam logic [2:0] RANK_NMI = 3'h1;
    localparam logic [2:0] RANK_FAULT = 3'h2;
    localparam logic [2:0] RANK_CFG_BASE = 3'h3;
    localparam logic [2:0] RANK_NONE = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Vector table and boot fetch addresses
    localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] FETCH_SP = 32'h0000_0000;
    localparam logic [31:0] FETCH_RST = 32'h0000_0004;
    localparam logic [31:0] FETCH_NMI = 32'h0000_0008;
    localparam logic [31:0] SUPERVISORY_ROM_NMI_OFS = 32'h0000_0008;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets and fields
    localparam logic [5:0] OFS_ENABLE = 6'h00;
    localparam logic [5:0] OFS_PRIO_LO = 6'h04;
    localparam logic [5:0] OFS_PRIO_HI = 6'h08;
    localparam logic [5:0] OFS_SYS_PRIO = 6'h0C;
    localparam logic [5:0] OFS_PENDING = 6'h10;
    localparam logic [5:0] OFS_ACTIVE = 6'h14;
    localparam logic [5:0] OFS_CONFIG = 6'h18;
    localparam logic [5:0] OFS_SYSTEM_CALL_REQUEST_BIT = 6'h1C;
    localparam logic [5:0] OFS_STATUS = 6'h20;
    localparam int CFG_SRAM_BIT = 0;
    localparam int SYSTEM_CALL_REQUEST_BIT_CALL_BIT = 0;
    localparam int SYSTEM_CALL_REQUEST_BIT_NOOVR_BIT = 1;
    localparam int STATUS_REQ_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
    localparam logic [63:0] RST_PRIO = 64'h0;
    localparam logic [5:0] RST_SYS_PRIO = 6'h00;
    localparam logic [31:0] RST_PENDING = 32'h0000_0000;
    localparam logic RST_SRAM_SEL = 1'h0;
    localparam logic [1:0] RST_SYSTEM_CALL_REQUEST_BIT = 2'h0;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        BUS_IDLE = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RRESP = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic nmi;
        logic fault;
        logic svc;
        logic deferred_service_exception;
        logic tick;
    } sys_src_t;

    typedef struct packed {
        logic entry_valid;
        logic [5:0] entry_num;
        logic exit_valid;
        logic [5:0] exit_num;
    } core_ack_t;

    typedef struct packed {
        logic irq_req;
        logic [5:0] exc_num;
        logic [31:0] vec_addr;
    } core_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } fetch_req_t;

    typedef struct packed {
        logic valid;
        logic from_supervisory_rom;
        logic [31:0] addr;
    } fetch_rsp_t;

endpackage

// [core/boot_fetch_redirect.sv]
`timescale 1ns/1ps
module boot_fetch_redirect (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Controls
    input wire logic redirect_disable,
    input wire logic syscall,
    // Fetch path
    input wire irq_ctrl_pkg::fetch_req_t req,
    output irq_ctrl_pkg::fetch_rsp_t rsp
);
    import irq_ctrl_pkg::*;

    typedef struct packed {
        fetch_rsp_t rsp;
    } fetch_state_t;

    fetch_state_t st_reg;
    fetch_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.rsp.valid = req.valid;
        st_next.rsp.from_supervisory_rom = 1'b0;
        st_next.rsp.addr = req.addr;
        if (req.valid) begin
            if ((req.addr == FETCH_SP || req.addr == FETCH_RST) &&
                !redirect_disable) begin
                st_next.rsp.from_supervisory_rom = 1'b1;
            end
            if (req.addr == FETCH_NMI && syscall) begin
                st_next.rsp.from_supervisory_rom = 1'b1;
                st_next.rsp.addr = SUPERVISORY_ROM_NMI_OFS;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rsp = st_reg.rsp;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_boot_redirect: assert property (@(posedge aclk) disable iff (!aresetn)
        req.valid && req.addr == FETCH_RST && !redirect_disable
        |=> rsp.from_supervisory_rom && rsp.addr == FETCH_RST)
        else $error("boot word fetch not served from rom");

    a_syscall_vector: assert property (@(posedge aclk) disable iff (!aresetn)
        req.valid && req.addr == FETCH_NMI
        |=> rsp.from_supervisory_rom == $past(syscall))
        else $error("nmi vector source does not follow syscall");

endmodule

// [core/vectored_irq_controller.sv]
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Behaviour
// - Thirty-two peripheral lines resolved and delivered
// - Two-bit priority per line, lower wins
// - Per-line enable; disabled lines never delivered
// - Rising edge sets sticky pending bit
// - Exception number presented with request
// - Pending clears when core enters handler
// - Edges during service collapse into one
// - Line high at handler exit repends
// - Most urgent pending request is forwarded
// - Higher priority preempts running handler
// - Lines map to exceptions 16..47, base+4n
// - NMI and fault outrank configurable levels
// - Exceptions 11,14,15 configurable; reserved never raised
// - Word zero is stack pointer, not exception
// - Select bit places table in sram or flash
// - Boot words redirected to rom unless disabled
// - Syscall bit redirects nmi vector fetch
// - Reset handler from rom, or flash if redirect disabled
module vectored_irq_controller #(
    parameter int N_LINES = irq_ctrl_pkg::LINES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus write
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // Register bus read
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt sources
    input wire logic [31:0] irq_lines,
    input wire irq_ctrl_pkg::sys_src_t sys_src,
    // Core side
    input wire irq_ctrl_pkg::core_ack_t core_ack,
    output irq_ctrl_pkg::core_req_t core_req,
    // Vector fetch path
    input wire irq_ctrl_pkg::fetch_req_t fetch_req,
    output irq_ctrl_pkg::fetch_rsp_t fetch_rsp
);
    import irq_ctrl_pkg::*;

    if (N_LINES < 1 || N_LINES > LINES) begin : g_bad_lines
        $error("N_LINES out of range");
    end

    localparam logic [31:0] LINE_MASK = 32'((64'h1 << N_LINES) - 64'h1);

    typedef struct packed {
        logic [31:0] enable;
        logic [63:0] prio;
        logic [5:0] sys_prio;
        logic [31:0] pending;
        logic [31:0] act_line;
        logic [4:0] act_sys;
        logic [31:0] line_prev;
        logic sram_sel;
        logic syscall;
        logic redir_dis;
        core_req_t req;
        bus_state_t bus;
        logic aw_got;
        logic w_got;
        logic [5:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [31:0] rdata;
        logic [1:0] resp;
    } ctrl_state_t;

    ctrl_state_t st_reg;
    ctrl_state_t st_next;
    logic [31:0] set_vec;
    logic [31:0] clr_vec;
    logic [31:0] exit_vec;
    logic [2:0] run_rank;
    logic [2:0] best_rank;
    logic [5:0] best_num;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] merge(logic [31:0] old,
                                          logic [31:0] val,
                                          logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [2:0] rank_of(logic [1:0] p);
        return RANK_CFG_BASE + {1'b0, p};
    endfunction

    function automatic logic [31:0] line_bit(logic v, logic [5:0] exc);
        logic [5:0] idx;
        idx = exc - EXC_LINE_FIRST;
        if (v && exc >= EXC_LINE_FIRST && exc <= EXC_LINE_LAST) begin
            return (32'h1 << idx[4:0]) & LINE_MASK;
        end
        return 32'h0;
    endfunction

    function automatic logic [4:0] sys_bit(logic v, logic [5:0] exc);
        if (!v) begin
            return 5'h00;
        end
        case (exc)
            EXC_NMI: return 5'h10;
            EXC_FAULT: return 5'h08;
            EXC_SVC: return 5'h04;
            EXC_DEFERRED_SERVICE_EXCEPTION: return 5'h02;
            EXC_TICK: return 5'h01;
            default: return 5'h00;
        endcase
    endfunction

    function automatic logic [31:0] vector_of(logic [5:0] exc, logic sram);
        logic [31:0] base;
        base = (sram && exc != EXC_RESET) ? SRAM_BASE : FLASH_BASE;
        return base + {24'h0, exc, 2'b00};
    endfunction

    function automatic logic mapped(logic [31:0] a);
        return a[31:6] == 26'h0 && a[1:0] == 2'b00 && a[5:0] <= OFS_STATUS;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pending and active tracking
    always_comb begin
        clr_vec = line_bit(core_ack.entry_valid, core_ack.entry_num);
        exit_vec = line_bit(core_ack.exit_valid, core_ack.exit_num);
        set_vec = irq_lines & ~st_reg.line_prev & LINE_MASK;
        set_vec = set_vec | (exit_vec & irq_lines);
    end

    ////////////////////////////////////////////////////////////////////////
    // Arbitration
    always_comb begin
        logic [2:0] r;
        logic [4:0] sreq;
        r = RANK_NONE;
        sreq = 5'h00;
        run_rank = RANK_NONE;
        best_rank = RANK_NONE;
        best_num = EXC_NONE;
        for (int i = 0; i < LINES; i++) begin
            r = rank_of(st_reg.prio[i*2 +: 2]);
            if (st_reg.act_line[i] && r < run_rank) begin
                run_rank = r;
            end
        end
        if (st_reg.act_sys[0] && rank_of(st_reg.sys_prio[5:4]) < run_rank) begin
            run_rank = rank_of(st_reg.sys_prio[5:4]);
        end
        if (st_reg.act_sys[1] && rank_of(st_reg.sys_prio[3:2]) < run_rank) begin
            run_rank = rank_of(st_reg.sys_prio[3:2]);
        end
        if (st_reg.act_sys[2] && rank_of(st_reg.sys_prio[1:0]) < run_rank) begin
            run_rank = rank_of(st_reg.sys_prio[1:0]);
        end
        if (st_reg.act_sys[3] && RANK_FAULT < run_rank) begin
            run_rank = RANK_FAULT;
        end
        if (st_reg.act_sys[4]) begin
            run_rank = RANK_NMI;
        end
        // Descending scan with <= makes the lowest number win a tie
        for (int i = LINES - 1; i >= 0; i--) begin
            r = rank_of(st_reg.prio[i*2 +: 2]);
            if (st_reg.pending[i] && st_reg.enable[i] && r <= best_rank) begin
                best_rank = r;
                best_num = EXC_LINE_FIRST + 6'(i);
            end
        end
        sreq = {sys_src.nmi | st_reg.syscall, sys_src.fault, sys_src.svc,
                sys_src.deferred_service_exception, sys_src.tick} & ~st_reg.act_sys;
        if (sreq[0] && rank_of(st_reg.sys_prio[5:4]) <= best_rank) begin
            best_rank = rank_of(st_reg.sys_prio[5:4]);
            best_num = EXC_TICK;
        end
        if (sreq[1] && rank_of(st_reg.sys_prio[3:2]) <= best_rank) begin
            best_rank = rank_of(st_reg.sys_prio[3:2]);
            best_num = EXC_DEFERRED_SERVICE_EXCEPTION;
        end
        if (sreq[2] && rank_of(st_reg.sys_prio[1:0]) <= best_rank) begin
            best_rank = rank_of(st_reg.sys_prio[1:0]);
            best_num = EXC_SVC;
        end
        if (sreq[3]) begin
            best_rank = RANK_FAULT;
            best_num = EXC_FAULT;
        end
        if (sreq[4]) begin
            best_rank = RANK_NMI;
            best_num = EXC_NMI;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [5:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic do_w;
        st_next = st_reg;
        a = st_reg.waddr;
        d = st_reg.wdata;
        s = st_reg.wstrb;
        do_w = 1'b0;
        st_next.line_prev = irq_lines;
        // Set wins over the clear of the same cycle
        st_next.pending = (st_reg.pending & ~clr_vec) | set_vec;
        st_next.act_line = (st_reg.act_line & ~exit_vec) | clr_vec;
        st_next.act_sys = (st_reg.act_sys &
                           ~sys_bit(core_ack.exit_valid, core_ack.exit_num)) |
                          sys_bit(core_ack.entry_valid, core_ack.entry_num);
        st_next.req.irq_req = best_rank < run_rank;
        st_next.req.exc_num = (best_rank < run_rank) ? best_num : EXC_NONE;
        st_next.req.vec_addr = vector_of(st_next.req.exc_num,
                                         st_reg.sram_sel);
        case (st_reg.bus)
            BUS_IDLE: begin
                if (awvalid && !st_reg.aw_got) begin
                    st_next.aw_got = 1'b1;
                    st_next.waddr = awaddr[5:0];
                    a = awaddr[5:0];
                end
                if (wvalid && !st_reg.w_got) begin
                    st_next.w_got = 1'b1;
                    st_next.wdata = wdata;
                    st_next.wstrb = wstrb;
                    d = wdata;
                    s = wstrb;
                end
                if (st_next.aw_got && st_next.w_got) begin
                    do_w = 1'b1;
                    st_next.aw_got = 1'b0;
                    st_next.w_got = 1'b0;
                    st_next.bus = BUS_WRESP;
                    st_next.resp = RESP_OKAY;
                    if (!mapped({awvalid && !st_reg.aw_got ?
                                 awaddr[31:6] : 26'h0, a})) begin
                        st_next.resp = RESP_SLVERR;
                        do_w = 1'b0;
                    end
                end else if (arvalid && !st_reg.aw_got && !st_reg.w_got) begin
                    st_next.bus = BUS_RRESP;
                    st_next.resp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
                    st_next.rdata = 32'h0;
                    if (mapped(araddr)) begin
                        case (araddr[5:0])
                            OFS_ENABLE: st_next.rdata = st_reg.enable;
                            OFS_PRIO_LO: st_next.rdata = st_reg.prio[31:0];
                            OFS_PRIO_HI: st_next.rdata = st_reg.prio[63:32];
                            OFS_SYS_PRIO: st_next.rdata = {26'h0, st_reg.sys_prio};
                            OFS_PENDING: st_next.rdata = st_reg.pending;
                            OFS_ACTIVE: st_next.rdata = st_reg.act_line;
                            OFS_CONFIG: st_next.rdata = {31'h0, st_reg.sram_sel};
                            OFS_SYSTEM_CALL_REQUEST_BIT: st_next.rdata = {30'h0, st_reg.redir_dis,
                                                         st_reg.syscall};
                            OFS_STATUS: st_next.rdata = {23'h0, st_reg.req.irq_req,
                                                         2'h0, st_reg.req.exc_num};
                            default: st_next.rdata = 32'h0;
                        endcase
                    end
                end
            end
            BUS_WRESP: begin
                if (bready) begin
                    st_next.bus = BUS_IDLE;
                end
            end
            BUS_RRESP: begin
                if (rready) begin
                    st_next.bus = BUS_IDLE;
                end
            end
            default: begin
                st_next.bus = BUS_IDLE;
            end
        endcase
        if (do_w) begin
            case (a)
                OFS_ENABLE: st_next.enable = merge(st_reg.enable, d, s) & LINE_MASK;
                OFS_PRIO_LO: st_next.prio[31:0] = merge(st_reg.prio[31:0], d, s);
                OFS_PRIO_HI: st_next.prio[63:32] = merge(st_reg.prio[63:32], d, s);
                OFS_SYS_PRIO: begin
                    if (s[0]) begin
                        st_next.sys_prio = d[5:0];
                    end
                end
                OFS_CONFIG: begin
                    if (s[0]) begin
                        st_next.sram_sel = d[CFG_SRAM_BIT];
                    end
                end
                OFS_SYSTEM_CALL_REQUEST_BIT: begin
                    if (s[0]) begin
                        st_next.syscall = d[SYSTEM_CALL_REQUEST_BIT_CALL_BIT];
                        st_next.redir_dis = d[SYSTEM_CALL_REQUEST_BIT_NOOVR_BIT];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.enable <= RST_ENABLE;
            st_reg.prio <= RST_PRIO;
            st_reg.sys_prio <= RST_SYS_PRIO;
            st_reg.pending <= RST_PENDING;
            st_reg.sram_sel <= RST_SRAM_SEL;
            st_reg.syscall <= RST_SYSTEM_CALL_REQUEST_BIT[SYSTEM_CALL_REQUEST_BIT_CALL_BIT];
            st_reg.redir_dis <= RST_SYSTEM_CALL_REQUEST_BIT[SYSTEM_CALL_REQUEST_BIT_NOOVR_BIT];
            st_reg.bus <= BUS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign awready = st_reg.bus == BUS_IDLE && !st_reg.aw_got;
    assign wready = st_reg.bus == BUS_IDLE && !st_reg.w_got;
    assign arready = st_reg.bus == BUS_IDLE && !st_reg.aw_got &&
                     !st_reg.w_got && !(awvalid && wvalid);
    assign bvalid = st_reg.bus == BUS_WRESP;
    assign rvalid = st_reg.bus == BUS_RRESP;
    assign bresp = st_reg.resp;
    assign rresp = st_reg.resp;
    assign rdata = st_reg.rdata;
    assign core_req = st_reg.req;

    boot_fetch_redirect u_fetch (
        .aclk(aclk),
        .aresetn(aresetn),
        .redirect_disable(st_reg.redir_dis),
        .syscall(st_reg.syscall),
        .req(fetch_req),
        .rsp(fetch_rsp)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    function automatic logic sreq_none();
        return !(sys_src.nmi | sys_src.fault | sys_src.svc |
                 sys_src.deferred_service_exception | sys_src.tick | st_reg.syscall);
    endfunction

    sequence s_exit_high;
        exit_vec != 32'h0 && (exit_vec & irq_lines) == exit_vec;
    endsequence

    a_rise_pending: assert property (
        set_vec != 32'h0 |=> (st_reg.pending & $past(set_vec)) == $past(set_vec))
        else $error("edge did not set pending");

    a_entry_clears: assert property (
        (clr_vec & ~set_vec) != 32'h0
        |=> (st_reg.pending & $past(clr_vec & ~set_vec)) == 32'h0)
        else $error("entry did not clear pending");

    a_exit_repend: assert property (
        s_exit_high |=> (st_reg.pending & $past(exit_vec)) == $past(exit_vec))
        else $error("high line at exit not pending");

    a_enabled_only: assert property (
        core_req.irq_req && core_req.exc_num >= EXC_LINE_FIRST
        |-> (($past(st_reg.enable) >> (core_req.exc_num - EXC_LINE_FIRST))
             & 32'h1) != 32'h0)
        else $error("disabled line delivered");

    a_vector_slot: assert property (
        core_req.irq_req |-> core_req.vec_addr[7:0] == {core_req.exc_num, 2'b00})
        else $error("vector offset wrong");

    a_table_base: assert property (
        core_req.irq_req |-> core_req.vec_addr[29] == $past(st_reg.sram_sel))
        else $error("vector base does not follow select");

    a_nmi_wins: assert property (
        (sys_src.nmi || st_reg.syscall) && !st_reg.act_sys[4]
        |=> core_req.irq_req && core_req.exc_num == EXC_NMI)
        else $error("nmi not delivered first");

    a_no_equal_nest: assert property (
        st_reg.act_line != 32'h0 && st_reg.act_sys == 5'h0 &&
        (st_reg.pending & ~st_reg.act_line) == 32'h0 && sreq_none()
        |=> !core_req.irq_req)
        else $error("same priority preempted");

    a_reset_clear: assert property (
        $past(!aresetn) |-> st_reg.enable == 32'h0 && st_reg.pending == 32'h0
        && !core_req.irq_req)
        else $error("state not cleared by reset");

endmodule

// [verif/core_model.sv]
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Core link
    input wire irq_ctrl_pkg::core_req_t core_req,
    output irq_ctrl_pkg::core_ack_t core_ack
);
    import irq_ctrl_pkg::*;
    logic [4:0] t_reg;
    logic [5:0] num_reg;
    always_ff @(posedge aclk) begin
        core_ack <= '0;
        if (!aresetn) begin
            t_reg <= '0;
        end else if (t_reg != 5'h00) begin
            t_reg <= t_reg - 5'h01;
            core_ack.exit_valid <= (t_reg == 5'h01);
            core_ack.exit_num <= num_reg;
        end else if (core_req.irq_req) begin
            core_ack.entry_valid <= 1'b1;
            core_ack.entry_num <= core_req.exc_num;
            num_reg <= core_req.exc_num;
            t_reg <= 5'h14;
        end
    end
endmodule

// [verif/testbench.sv]
`timescale 1ns/1ps
module testbench;
    import irq_ctrl_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, irq_lines = 0, rdata;
    logic [1:0] bresp, rresp, resp;
    core_req_t core_req;
    core_ack_t core_ack;
    sys_src_t sys_src = '0;
    fetch_req_t fetch_req = '0;
    fetch_rsp_t fetch_rsp;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    vectored_irq_controller i_dut (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .irq_lines(irq_lines), .sys_src(sys_src),
        .core_ack(core_ack), .core_req(core_req),
        .fetch_req(fetch_req), .fetch_rsp(fetch_rsp));
    core_model i_core (.aclk(aclk), .aresetn(aresetn),
        .core_req(core_req), .core_ack(core_ack));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= {26'h0, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(RESP_OKAY), 32'(bresp));
    endtask
    task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] e);
        @(posedge aclk);
        araddr <= {26'h0, a};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        resp = rresp;
        chk(nm, e, rdata);
    endtask
    task automatic wait_irq(input logic [5:0] e);
        int k;
        k = 0;
        do begin
            @(posedge aclk);
            k++;
        end while (!core_req.irq_req && k < 40);
        chk("exc_num", 32'(e), 32'(core_req.exc_num));
    endtask
    task automatic pulse(input int n);
        @(posedge aclk);
        irq_lines[n] <= 1'b1;
        @(posedge aclk);
        irq_lines[n] <= 1'b0;
    endtask
    task automatic fch(input logic [31:0] a, input logic e);
        @(posedge aclk);
        fetch_req <= {1'b1, a};
        @(posedge aclk);
        fetch_req.valid <= 1'b0;
        @(posedge aclk);
        chk("from_supervisory_rom", 32'(e), 32'(fetch_rsp.from_supervisory_rom));
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_deliver();
        rd("enable", OFS_ENABLE, 32'h0);
        rd("unmapped", 6'h24, 32'h0);
        chk("rresp", 32'(RESP_SLVERR), 32'(resp));
        pulse(3);
        repeat (4) @(posedge aclk);
        chk("irq_req", 32'h0, 32'(core_req.irq_req));
        rd("pending", OFS_PENDING, 32'h8);
        wr(OFS_CONFIG, 32'h1);
        wr(OFS_ENABLE, 32'h8);
        wait_irq(6'h13);
        chk("vec_addr", 32'h2000_004C, core_req.vec_addr);
        rd("pending", OFS_PENDING, 32'h0);
        pulse(3);
        pulse(3);
        rd("pending", OFS_PENDING, 32'h8);
        wait_irq(6'h13);
        wr(OFS_ENABLE, 32'h0);
    endtask
    task automatic t_prio();
        repeat (30) @(posedge aclk);
        pulse(1);
        pulse(2);
        wr(OFS_PRIO_LO, 32'h18);
        wr(OFS_ENABLE, 32'h6);
        wait_irq(6'h12);
        repeat (4) @(posedge aclk);
        wait_irq(6'h11);
        repeat (4) @(posedge aclk);
        pulse(2);
        wait_irq(6'h12);
        repeat (50) @(posedge aclk);
        wr(OFS_ENABLE, 32'h20);
        irq_lines[5] <= 1'b1;
        wait_irq(6'h15);
        repeat (4) @(posedge aclk);
        wait_irq(6'h15);
        irq_lines[5] <= 1'b0;
        repeat (2) @(posedge aclk);
        sys_src.fault <= 1'b1;
        wait_irq(EXC_FAULT);
        sys_src.fault <= 1'b0;
    endtask
    task automatic t_fetch();
        fch(FETCH_RST, 1'b1);
        wr(OFS_SYSTEM_CALL_REQUEST_BIT, 32'h2);
        fch(FETCH_SP, 1'b0);
        fch(FETCH_NMI, 1'b0);
        wr(OFS_SYSTEM_CALL_REQUEST_BIT, 32'h1);
        fch(FETCH_NMI, 1'b1);
        wr(OFS_SYSTEM_CALL_REQUEST_BIT, 32'h0);
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_deliver();
        t_prio();
        t_fetch();
        give_verdict();
    end
endmodule
